// [common/exec_unit_consts.vh]
// Constants for the bit, transfer and control execution unit
`ifndef EXEC_UNIT_CONSTS_VH
`define EXEC_UNIT_CONSTS_VH

// Register byte offsets on the APB side
`define OFS_COMMAND 8'h00
`define OFS_OPERAND 8'h04
`define OFS_STATUS 8'h08
`define OFS_REG_SELECT 8'h0c
`define OFS_REG_DATA 8'h10
`define OFS_STACK_PTR 8'h14
`define OFS_FLAGS 8'h18

// Command word fields
`define CMD_OP 4:0
`define CMD_PTR 6:5
`define CMD_MODE 9:8
`define CMD_BIT 14:12
`define CMD_RD 20:16
`define CMD_RR 28:24

// Operation codes
`define OP_NOP 5'h00
`define OP_ROTATE_RIGHT_CARRY 5'h01
`define OP_ARITH_SHIFT_RIGHT 5'h02
`define OP_NIBBLE_SWAP 5'h03
`define OP_FLAG_SET 5'h04
`define OP_FLAG_CLEAR 5'h05
`define OP_BIT_TO_T_FLAG 5'h06
`define OP_T_FLAG_TO_BIT 5'h07
`define OP_REG_MOVE 5'h08
`define OP_REGISTER_PAIR_COPY 5'h09
`define OP_LOAD_IMMEDIATE 5'h0a
`define OP_INDIRECT_LOAD 5'h0b
`define OP_DISPLACED_LOAD 5'h0c
`define OP_DIRECT_LOAD 5'h0d
`define OP_INDIRECT_STORE 5'h0e
`define OP_DISPLACED_STORE 5'h0f
`define OP_DIRECT_STORE 5'h10
`define OP_PROGRAM_MEMORY_READ 5'h11
`define OP_STACK_PUSH 5'h12
`define OP_STACK_POP 5'h13
`define OP_SLEEP 5'h14
`define OP_WATCHDOG_RESTART 5'h15

// Status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// Pointer selection and addressing modes
`define PTR_X 2'h0
`define PTR_Y 2'h1
`define PTR_Z 2'h2
`define MODE_PLAIN 2'h0
`define MODE_POST_INC 2'h1
`define MODE_PRE_DEC 2'h2
`define MODE_IMPLIED_R0 2'h3

// Low register of each pointer pair
`define X_LOW 5'h1a
`define Y_LOW 5'h1c
`define Z_LOW 5'h1e

// Reset values
`define FLAGS_RESET 8'h00
`define STACK_PTR_RESET 16'h00ff
`define COMMAND_RESET 32'h0000_0000

`endif

// [rtl/bit_transfer_exec.v]
// Execution unit for shifts, flag and bit moves, data transfers and controls
//
// Added by the designer: the register offsets and the APB slave port.
`default_nettype none
`include "exec_unit_consts.vh"

module bit_transfer_exec (
  input wire ref_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [15:0] dmemAddr,
  output reg [7:0] dmemWdata,
  output reg dmemWrite,
  output reg dmemRead,
  input wire [7:0] dmemRdata,
  output reg [15:0] pmemAddr,
  output reg pmemRead,
  input wire [7:0] pmemRdata,
  output reg sleepRequest,
  output reg watchdogRestart
);

  localparam PH_IDLE = 2'h0;
  localparam PH_ONE = 2'h1;
  localparam PH_TWO = 2'h2;
  localparam PH_THREE = 2'h3;

  reg [7:0] regFile [0:31];
  reg [7:0] flags;
  reg [15:0] stackPointer;
  reg [31:0] command;
  reg [15:0] operand;
  reg [4:0] regSelect;
  reg [1:0] phase;
  integer i;

  wire [4:0] cmdOp = command[`CMD_OP];
  wire [1:0] cmdPtr = command[`CMD_PTR];
  wire [1:0] cmdMode = command[`CMD_MODE];
  wire [2:0] cmdBit = command[`CMD_BIT];
  wire [4:0] cmdRd = command[`CMD_RD];
  wire [4:0] cmdRr = command[`CMD_RR];
  wire busy = (phase != PH_IDLE);
  wire apbAccess = psel && penable && !pready;

  reg [4:0] ptrLow;
  reg [15:0] ptrVal;
  reg [15:0] ptrIncr;
  reg [15:0] ptrDecr;
  reg [15:0] next_memAddr;
  reg [15:0] next_ptr;
  reg ptrUpdate;
  reg [7:0] rdVal;
  reg [7:0] rrVal;
  reg [7:0] shiftRes;
  reg [7:0] next_flags;
  reg [7:0] bitRes;
  reg addrMapped;
  reg [31:0] readMux;
  reg [4:0] loadTarget;

  // Pointer selection and address generation
  always @* begin
    case (cmdPtr)
      `PTR_Y: ptrLow = `Y_LOW;
      `PTR_Z: ptrLow = `Z_LOW;
      default: ptrLow = `X_LOW;
    endcase
    if (cmdOp == `OP_PROGRAM_MEMORY_READ) begin
      ptrLow = `Z_LOW;
    end
    ptrVal = {regFile[ptrLow + 5'h01], regFile[ptrLow]};
    ptrIncr = ptrVal + 16'h0001;
    ptrDecr = ptrVal - 16'h0001;
    next_memAddr = ptrVal;
    next_ptr = ptrVal;
    ptrUpdate = 1'b0;
    case (cmdOp)
      `OP_INDIRECT_LOAD, `OP_INDIRECT_STORE: begin
        if (cmdMode == `MODE_PRE_DEC) begin
          next_memAddr = ptrDecr;
          next_ptr = ptrDecr;
          ptrUpdate = 1'b1;
        end else if (cmdMode == `MODE_POST_INC) begin
          next_ptr = ptrIncr;
          ptrUpdate = 1'b1;
        end
      end
      `OP_DISPLACED_LOAD, `OP_DISPLACED_STORE: begin
        next_memAddr = ptrVal + {10'h000, operand[5:0]};
      end
      `OP_DIRECT_LOAD, `OP_DIRECT_STORE: begin
        next_memAddr = operand;
      end
      `OP_STACK_PUSH: begin
        next_memAddr = stackPointer;
      end
      `OP_STACK_POP: begin
        next_memAddr = stackPointer + 16'h0001;
      end
      `OP_PROGRAM_MEMORY_READ: begin
        if (cmdMode == `MODE_POST_INC) begin
          next_ptr = ptrIncr;
          ptrUpdate = 1'b1;
        end
      end
      default: begin
        next_memAddr = ptrVal;
      end
    endcase
  end

  // Single-clock results and flags
  always @* begin
    rdVal = regFile[cmdRd];
    rrVal = regFile[cmdRr];
    next_flags = flags;
    shiftRes = rdVal;
    bitRes = rdVal;
    bitRes[cmdBit] = flags[`FLAG_T];
    case (cmdOp)
      `OP_ROTATE_RIGHT_CARRY: begin
        shiftRes = {flags[`FLAG_C], rdVal[7:1]};
      end
      `OP_ARITH_SHIFT_RIGHT: begin
        shiftRes = {rdVal[7], rdVal[7:1]};
      end
      default: begin
        shiftRes = rdVal;
      end
    endcase
    case (cmdOp)
      `OP_ROTATE_RIGHT_CARRY, `OP_ARITH_SHIFT_RIGHT: begin
        next_flags[`FLAG_C] = rdVal[0];
        next_flags[`FLAG_Z] = (shiftRes == 8'h00);
        next_flags[`FLAG_N] = shiftRes[7];
        next_flags[`FLAG_V] = shiftRes[7] ^ rdVal[0];
      end
      `OP_FLAG_SET: begin
        next_flags[cmdBit] = 1'b1;
      end
      `OP_FLAG_CLEAR: begin
        next_flags[cmdBit] = 1'b0;
      end
      `OP_BIT_TO_T_FLAG: begin
        next_flags[`FLAG_T] = rrVal[cmdBit];
      end
      default: begin
        next_flags = flags;
      end
    endcase
  end

  // Register read mux and address decode
  always @* begin
    addrMapped = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      `OFS_COMMAND: readMux = command;
      `OFS_OPERAND: readMux = {16'h0000, operand};
      `OFS_STATUS: readMux = {16'h0000, flags, 7'h00, busy};
      `OFS_REG_SELECT: readMux = {27'h000_0000, regSelect};
      `OFS_REG_DATA: readMux = {24'h00_0000, regFile[regSelect]};
      `OFS_STACK_PTR: readMux = {16'h0000, stackPointer};
      `OFS_FLAGS: readMux = {24'h00_0000, flags};
      default: addrMapped = 1'b0;
    endcase
    if (cmdMode == `MODE_IMPLIED_R0) begin
      loadTarget = 5'h00;
    end else begin
      loadTarget = cmdRd;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < 32; i = i + 1) begin
        regFile[i] <= 8'h00;
      end
      flags <= `FLAGS_RESET;
      stackPointer <= `STACK_PTR_RESET;
      command <= `COMMAND_RESET;
      operand <= 16'h0000;
      regSelect <= 5'h00;
      phase <= PH_IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      dmemAddr <= 16'h0000;
      dmemWdata <= 8'h00;
      dmemWrite <= 1'b0;
      dmemRead <= 1'b0;
      pmemAddr <= 16'h0000;
      pmemRead <= 1'b0;
      sleepRequest <= 1'b0;
      watchdogRestart <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      dmemWrite <= 1'b0;
      dmemRead <= 1'b0;
      sleepRequest <= 1'b0;
      watchdogRestart <= 1'b0;

      // Writes wait while a command runs; reads answer at once
      if (apbAccess && !(pwrite && busy)) begin
        pready <= 1'b1;
        pslverr <= !addrMapped;
        if (pwrite) begin
          case (paddr)
            `OFS_COMMAND: begin
              command <= pwdata;
              phase <= PH_ONE;
            end
            `OFS_OPERAND: operand <= pwdata[15:0];
            `OFS_REG_SELECT: regSelect <= pwdata[4:0];
            `OFS_REG_DATA: regFile[regSelect] <= pwdata[7:0];
            `OFS_STACK_PTR: stackPointer <= pwdata[15:0];
            `OFS_FLAGS: flags <= pwdata[7:0];
            default: regSelect <= regSelect;
          endcase
        end else begin
          prdata <= readMux;
        end
      end

      case (phase)
        PH_IDLE: begin
          // No phase write here, so a command store above can start phase one
        end
        PH_ONE: begin
          flags <= next_flags;
          phase <= PH_IDLE;
          case (cmdOp)
            `OP_ROTATE_RIGHT_CARRY, `OP_ARITH_SHIFT_RIGHT: begin
              regFile[cmdRd] <= shiftRes;
            end
            `OP_NIBBLE_SWAP: begin
              regFile[cmdRd] <= {rdVal[3:0], rdVal[7:4]};
            end
            `OP_T_FLAG_TO_BIT: begin
              regFile[cmdRd] <= bitRes;
            end
            `OP_REG_MOVE: begin
              regFile[cmdRd] <= rrVal;
            end
            `OP_REGISTER_PAIR_COPY: begin
              regFile[{cmdRd[4:1], 1'b0}] <= regFile[{cmdRr[4:1], 1'b0}];
              regFile[{cmdRd[4:1], 1'b1}] <= regFile[{cmdRr[4:1], 1'b1}];
            end
            `OP_LOAD_IMMEDIATE: begin
              regFile[cmdRd] <= operand[7:0];
            end
            `OP_INDIRECT_LOAD, `OP_DISPLACED_LOAD, `OP_DIRECT_LOAD: begin
              dmemAddr <= next_memAddr;
              dmemRead <= 1'b1;
              phase <= PH_TWO;
            end
            `OP_INDIRECT_STORE, `OP_DISPLACED_STORE, `OP_DIRECT_STORE: begin
              dmemAddr <= next_memAddr;
              dmemWdata <= rrVal;
              dmemWrite <= 1'b1;
              phase <= PH_TWO;
            end
            `OP_STACK_PUSH: begin
              dmemAddr <= next_memAddr;
              dmemWdata <= rrVal;
              dmemWrite <= 1'b1;
              stackPointer <= stackPointer - 16'h0001;
              phase <= PH_TWO;
            end
            `OP_STACK_POP: begin
              dmemAddr <= next_memAddr;
              dmemRead <= 1'b1;
              stackPointer <= next_memAddr;
              phase <= PH_TWO;
            end
            `OP_PROGRAM_MEMORY_READ: begin
              pmemAddr <= ptrVal;
              pmemRead <= 1'b1;
              phase <= PH_TWO;
            end
            `OP_SLEEP: begin
              sleepRequest <= 1'b1;
            end
            `OP_WATCHDOG_RESTART: begin
              watchdogRestart <= 1'b1;
            end
            default: begin
              phase <= PH_IDLE;
            end
          endcase
          if (ptrUpdate) begin
            regFile[ptrLow] <= next_ptr[7:0];
            regFile[ptrLow + 5'h01] <= next_ptr[15:8];
          end
        end
        PH_TWO: begin
          case (cmdOp)
            `OP_INDIRECT_LOAD, `OP_DISPLACED_LOAD, `OP_DIRECT_LOAD, `OP_STACK_POP: begin
              regFile[cmdRd] <= dmemRdata;
              phase <= PH_IDLE;
            end
            `OP_PROGRAM_MEMORY_READ: begin
              phase <= PH_THREE;
            end
            default: begin
              phase <= PH_IDLE;
            end
          endcase
        end
        PH_THREE: begin
          regFile[loadTarget] <= pmemRdata;
          pmemRead <= 1'b0;
          phase <= PH_IDLE;
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

endmodule // bit_transfer_exec
`default_nettype wire

// [dv/exec_unit_props.sv]
// Port-level checks of the execution unit
`default_nettype none
module exec_unit_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pready,
  input wire logic dmemWrite,
  input wire logic dmemRead,
  input wire logic pmemRead,
  input wire logic [15:0] pmemAddr,
  input wire logic sleepRequest,
  input wire logic watchdogRestart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rd_pulse;
    dmemRead |=> !dmemRead;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_wr_pulse;
    dmemWrite |=> !dmemWrite;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_rd_cause;
    $rose(dmemRead) |-> $past(pready);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read not after command");
  property p_wr_cause;
    $rose(dmemWrite) |-> $past(pready);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write not after command");
  property p_excl;
    dmemWrite |-> !dmemRead && !pmemRead;
  endproperty
  a_excl: assert property (p_excl) else $error("overlapping memory strobes");
  property p_pm_len;
    $rose(pmemRead) |-> $past(pready) ##1 pmemRead ##1 !pmemRead;
  endproperty
  a_pm_len: assert property (p_pm_len) else $error("program read length wrong");
  property p_pm_addr;
    pmemRead && $past(pmemRead) |-> $stable(pmemAddr);
  endproperty
  a_pm_addr: assert property (p_pm_addr) else $error("program address moved");
  property p_sleep;
    sleepRequest |-> $past(pready) ##1 !sleepRequest;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep pulse wrong");
  property p_wdr;
    watchdogRestart |-> $past(pready) ##1 !watchdogRestart;
  endproperty
  a_wdr: assert property (p_wdr) else $error("restart pulse wrong");
  c_store: cover property (dmemWrite);
  c_prog: cover property ($rose(pmemRead));
  c_sleep: cover property (sleepRequest);
endmodule // exec_unit_props

bind bit_transfer_exec exec_unit_props u_props (.ref_clk(ref_clk), .reset(reset),
  .pready(pready), .dmemWrite(dmemWrite), .dmemRead(dmemRead), .pmemRead(pmemRead),
  .pmemAddr(pmemAddr), .sleepRequest(sleepRequest), .watchdogRestart(watchdogRestart));
`default_nettype wire

// [dv/exec_mem_model.sv]
// Data and program memory seen by the execution unit
`default_nettype none
module exec_mem_model (
  input wire logic ref_clk,
  input wire logic [15:0] dmemAddr,
  input wire logic [7:0] dmemWdata,
  input wire logic dmemWrite,
  input wire logic dmemRead,
  output logic [7:0] dmemRdata,
  input wire logic [15:0] pmemAddr,
  input wire logic pmemRead,
  output logic [7:0] pmemRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (dmemWrite) mem[dmemAddr[7:0]] <= dmemWdata;
  end
  // Outside a strobe the lines show inverted data, never a stale match
  assign dmemRdata = dmemRead ? mem[dmemAddr[7:0]] : ~mem[dmemAddr[7:0]];
  assign pmemRdata = (pmemAddr[7:0] ^ 8'ha5) ^ {8{!pmemRead}};
endmodule // exec_mem_model
`default_nettype wire

// [dv/test_cpu_bit_transfer_control_exec.sv]
// Self-checking bench for the execution unit
`default_nettype none
`include "exec_unit_consts.vh"
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nFail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_cpu_bit_transfer_control_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic dmemWrite, dmemRead, pmemRead, sleepRequest, watchdogRestart;
  logic [7:0] paddr, dmemWdata, dmemRdata, pmemRdata;
  logic [15:0] dmemAddr, pmemAddr;
  logic [31:0] pwdata, prdata, rdat;
  int nFail = 0;
  int numChecks = 0;
  int nSleep = 0;
  int nWdr = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (sleepRequest === 1'b1) nSleep++;
    if (watchdogRestart === 1'b1) nWdr++;
  end
  bit_transfer_exec dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dmemAddr(dmemAddr), .dmemWdata(dmemWdata), .dmemWrite(dmemWrite),
    .dmemRead(dmemRead), .dmemRdata(dmemRdata), .pmemAddr(pmemAddr), .pmemRead(pmemRead),
    .pmemRdata(pmemRdata), .sleepRequest(sleepRequest), .watchdogRestart(watchdogRestart));
  exec_mem_model mem (.ref_clk(ref_clk), .dmemAddr(dmemAddr), .dmemWdata(dmemWdata),
    .dmemWrite(dmemWrite), .dmemRead(dmemRead), .dmemRdata(dmemRdata),
    .pmemAddr(pmemAddr), .pmemRead(pmemRead), .pmemRdata(pmemRdata));
  task conclude;
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Values read just after an edge are the ones that edge sampled
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      nFail++;
      conclude();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK($sformatf("addr %h", a), e, rdat)
  endtask
  task setReg(input logic [4:0] i, input logic [7:0] v);
    apb(1'b1, 8'h0c, {27'h0, i});
    apb(1'b1, 8'h10, {24'h0, v});
  endtask
  task chkReg(input logic [4:0] i, input logic [7:0] e);
    apb(1'b1, 8'h0c, {27'h0, i});
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK($sformatf("r%0d", i), {24'h0, e}, rdat)
  endtask
  task setPtr(input logic [4:0] l, input logic [15:0] v);
    setReg(l, v[7:0]);
    setReg(l + 5'h01, v[15:8]);
  endtask
  task cmd(input logic [4:0] op, input logic [4:0] d = 5'h00, s = 5'h00,
      input logic [1:0] p = 2'h0, m = 2'h0, input logic [2:0] b = 3'h0);
    int n;
    apb(1'b1, 8'h00, {3'h0, s, 3'h0, d, 1'b0, b, 2'h0, m, 1'b0, p, op});
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0000_0000);
      n++;
    end while (rdat[0] !== 1'b0 && n < 20);
    if (rdat[0] !== 1'b0) begin
      nFail++;
      conclude();
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    setReg(5'h01, 8'h81);
    apb(1'b1, 8'h18, 32'h0000_0001);
    cmd(`OP_ROTATE_RIGHT_CARRY, 5'h01);
    chkReg(5'h01, 8'hc0);
    rd(8'h18, 32'h0000_0005);
    setReg(5'h02, 8'h80);
    cmd(`OP_ARITH_SHIFT_RIGHT, 5'h02);
    chkReg(5'h02, 8'hc0);
    rd(8'h18, 32'h0000_000c);
    setReg(5'h03, 8'h5a);
    cmd(`OP_NIBBLE_SWAP, 5'h03);
    chkReg(5'h03, 8'ha5);
    rd(8'h18, 32'h0000_000c);
    for (int b = 3; b < 6; b++) begin
      apb(1'b1, 8'h18, 32'h0000_0000);
      cmd(`OP_FLAG_SET, 5'h00, 5'h00, 2'h0, 2'h0, b[2:0]);
      rd(8'h18, 32'h1 << b);
      apb(1'b1, 8'h18, 32'h0000_00ff);
      cmd(`OP_FLAG_CLEAR, 5'h00, 5'h00, 2'h0, 2'h0, b[2:0]);
      rd(8'h18, 32'hff ^ (32'h1 << b));
    end
    apb(1'b1, 8'h18, 32'h0000_0000);
    setReg(5'h04, 8'h10);
    cmd(`OP_BIT_TO_T_FLAG, 5'h00, 5'h04, 2'h0, 2'h0, 3'h4);
    rd(8'h18, 32'h0000_0040);
    setReg(5'h05, 8'h01);
    cmd(`OP_T_FLAG_TO_BIT, 5'h05, 5'h00, 2'h0, 2'h0, 3'h2);
    chkReg(5'h05, 8'h05);
    rd(8'h18, 32'h0000_0040);
    setReg(5'h0a, 8'h11);
    setReg(5'h0b, 8'h22);
    cmd(`OP_REGISTER_PAIR_COPY, 5'h0c, 5'h0a);
    chkReg(5'h0c, 8'h11);
    chkReg(5'h0d, 8'h22);
    // Plain register move and immediate load
    cmd(`OP_REG_MOVE, 5'h11, 5'h0a);
    chkReg(5'h11, 8'h11);
    apb(1'b1, 8'h04, 32'h0000_003c);
    cmd(`OP_LOAD_IMMEDIATE, 5'h12);
    chkReg(5'h12, 8'h3c);
    setReg(5'h06, 8'h3c);
    setPtr(`Y_LOW, 16'h0020);
    cmd(`OP_INDIRECT_STORE, 5'h00, 5'h06, `PTR_Y, `MODE_POST_INC);
    chkReg(`Y_LOW, 8'h21);
    cmd(`OP_INDIRECT_LOAD, 5'h07, 5'h00, `PTR_Y, `MODE_PRE_DEC);
    chkReg(5'h07, 8'h3c);
    chkReg(`Y_LOW, 8'h20);
    setReg(5'h06, 8'h77);
    setPtr(`Z_LOW, 16'h0031);
    cmd(`OP_INDIRECT_STORE, 5'h00, 5'h06, `PTR_Z, `MODE_PRE_DEC);
    chkReg(`Z_LOW, 8'h30);
    setPtr(`X_LOW, 16'h0030);
    cmd(`OP_INDIRECT_LOAD, 5'h08, 5'h00, `PTR_X, `MODE_POST_INC);
    chkReg(5'h08, 8'h77);
    chkReg(`X_LOW, 8'h31);
    apb(1'b1, 8'h04, 32'h0000_0005);
    cmd(`OP_DISPLACED_STORE, 5'h00, 5'h06, `PTR_Y);
    chkReg(`Y_LOW, 8'h20);
    apb(1'b1, 8'h04, 32'h0000_0025);
    cmd(`OP_DIRECT_LOAD, 5'h09);
    chkReg(5'h09, 8'h77);
    apb(1'b1, 8'h04, 32'h0000_0042);
    cmd(`OP_DIRECT_STORE, 5'h00, 5'h01);
    apb(1'b1, 8'h04, 32'h0000_0012);
    cmd(`OP_DISPLACED_LOAD, 5'h0e, 5'h00, `PTR_Z);
    chkReg(5'h0e, 8'hc0);
    chkReg(`Z_LOW, 8'h30);
    cmd(`OP_STACK_PUSH, 5'h00, 5'h03);
    rd(8'h14, 32'h0000_00fe);
    cmd(`OP_STACK_POP, 5'h0f);
    chkReg(5'h0f, 8'ha5);
    rd(8'h14, 32'h0000_00ff);
    setPtr(`Z_LOW, 16'h0112);
    cmd(`OP_PROGRAM_MEMORY_READ, 5'h10, 5'h00, `PTR_Z, `MODE_POST_INC);
    chkReg(5'h10, 8'hb7);
    chkReg(`Z_LOW, 8'h13);
    cmd(`OP_PROGRAM_MEMORY_READ, 5'h00, 5'h00, `PTR_Z, `MODE_IMPLIED_R0);
    chkReg(5'h00, 8'hb6);
    cmd(`OP_PROGRAM_MEMORY_READ, 5'h14, 5'h00, `PTR_Z, `MODE_PLAIN);
    chkReg(5'h14, 8'hb6);
    chkReg(`Z_LOW, 8'h13);
    cmd(`OP_SLEEP);
    cmd(`OP_WATCHDOG_RESTART);
    cmd(`OP_NOP);
    `CHK("sleep pulses", 1, nSleep)
    `CHK("restart pulses", 1, nWdr)
    rd(8'h18, 32'h0000_0040);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rdat)
    conclude();
  end
endmodule // test_cpu_bit_transfer_control_exec
`default_nettype wire
